// ### ser_checker.sv
// Checker of the status and event block's answers and summary byte.
// Assumes a bind onto ser_status_event; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ser_checker (
	// Watched ports.
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	input wire logic query_i,
	input wire logic clear_status_i,
	input wire logic [1:0] query_sel_i,
	input wire logic output_available_i,
	input wire logic error_pending_i,
	input wire logic [7:0] resp_data_o,
	input wire logic resp_valid_o,
	input wire logic error_clear_o,
	input wire logic [7:0] status_summary_byte_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	sequence s_query;
		query_i && ce_i;
	endsequence
	sequence s_clear;
		clear_status_i && ce_i;
	endsequence
	a_query_answer: assert property (s_query |=> resp_valid_o) else $error("no answer");
	a_answer_cause: assert property (!query_i && ce_i |=> !resp_valid_o) else $error("stray");
	a_clear_notify: assert property (s_clear |=> error_clear_o) else $error("no clear");
	a_clear_cause: assert property (!clear_status_i && ce_i |=> !error_clear_o)
		else $error("stray clear");
	a_flag_gaps: assert property (resp_valid_o && $past(query_sel_i) == 2'h1 |->
		resp_data_o[6] == 1'h0 && resp_data_o[1] == 1'h0) else $error("flag gap");
	a_srq_gaps: assert property (resp_valid_o && $past(query_sel_i) == 2'h2 |->
		resp_data_o[6] == 1'h0 && resp_data_o[1:0] == 2'h0) else $error("mask gap");
	a_status_gaps: assert property (status_summary_byte_o[6] == 1'h0 &&
		status_summary_byte_o[1:0] == 2'h0) else $error("status gap");
	a_level_follow: assert property (ce_i |=> status_summary_byte_o[4] == $past(output_available_i)
		&& status_summary_byte_o[2] == $past(error_pending_i)) else $error("level lag");
endmodule // ser_checker
bind ser_status_event ser_checker ser_checker_inst (.clk_i, .arst_n_i, .ce_i, .query_i,
	.clear_status_i, .query_sel_i, .output_available_i, .error_pending_i, .resp_data_o,
	.resp_valid_o, .error_clear_o, .status_summary_byte_o);
`default_nettype wire

// ### ser_defines.vh
// Constants of the status and event reporting block: bit positions, reset values, query codes.
// Assumes inclusion by its bare name from the design files.
`ifndef SER_DEFINES_VH
`define SER_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Standard event flag and mask bit positions.
`define SER_EV_POWER_ON 7
`define SER_EV_USER_REQUEST 6
`define SER_EV_CMD_FAULT 5
`define SER_EV_RUN_FAULT 4
`define SER_EV_DEV_FAULT 3
`define SER_EV_QUERY_FAULT 2
`define SER_EV_CONTROL_REQUEST 1
`define SER_EV_OP_COMPLETE 0

////////////////////////////////////////////////////////////////////////////////
// Status summary byte and service request mask bit positions.
`define SER_SB_AUX_HIGH 7
`define SER_SB_EVENT_SUMMARY 5
`define SER_SB_OUTPUT_AVAILABLE 4
`define SER_SB_AUX_LOW 3
`define SER_SB_ERROR_SUMMARY 2

////////////////////////////////////////////////////////////////////////////////
// Reset values and implemented-bit masks.
`define SER_EVENT_MASK_RESET 8'h00
`define SER_SRQ_MASK_RESET 8'h00
`define SER_FLAGS_RESET 8'h80
`define SER_FLAGS_USED 8'hBD
`define SER_SRQ_USED 8'hBC
`define SER_STATUS_RESET 8'h00
`define SER_RESP_RESET 8'h00
`define SER_PULSE_RESET 1'h0

////////////////////////////////////////////////////////////////////////////////
// Query select codes.
`define SER_Q_EVENT_MASK 2'h0
`define SER_Q_EVENT_FLAGS 2'h1
`define SER_Q_SRQ_MASK 2'h2
`define SER_Q_STATUS_BYTE 2'h3

`endif

// ### ser_flags.v
// Sticky standard event flag register: per-bit set and clear, set wins.
// Assumes set and clear pulses come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "ser_defines.vh"

module ser_flags (
	// Clock, reset and enable.
	input wire clk_i,
	input wire arst_n_i,
	input wire ce_i,
	// Per-bit set and clear.
	input wire [7:0] set_i,
	input wire [7:0] clr_i,
	// Flags.
	output wire [7:0] flags_o
);

	reg [7:0] flags_q;
	wire [7:0] flags_d;

	// A set arriving with a clear is kept, so no event is lost to a read or clear.
	assign flags_d = ((flags_q & ~clr_i) | set_i) & `SER_FLAGS_USED; // R07

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			flags_q <= `SER_FLAGS_RESET;
		end else if (ce_i) begin
			flags_q <= flags_d;
		end
	end

	assign flags_o = flags_q;

endmodule // ser_flags
`default_nettype wire

// ### ser_remote_ctl.sv
// Remote controller model issuing status commands and queries.
// Assumes the block samples on the rising edge; this drives at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module ser_remote_ctl (
	// Clock.
	input wire logic clk_i,
	// Strobes: clear, event mask, service mask, operation complete.
	output logic [3:0] cmd_o,
	output logic [7:0] wr_data_o,
	// Query.
	output logic query_o,
	output logic [1:0] query_sel_o
);
	initial begin
		cmd_o = 4'h0;
		wr_data_o = 8'h00;
		query_o = 1'h0;
		query_sel_o = 2'h0;
	end
	// Released data is inverted so a stale value can never be mistaken for a write.
	task automatic send(input int k, input logic [7:0] d);
		@(negedge clk_i);
		cmd_o[k] = 1'h1;
		wr_data_o = d;
		@(negedge clk_i);
		cmd_o = 4'h0;
		wr_data_o = ~d;
	endtask
	task automatic ask(input logic [1:0] s);
		@(negedge clk_i);
		query_o = 1'h1;
		query_sel_o = s;
		@(negedge clk_i);
		query_o = 1'h0;
		query_sel_o = ~s;
	endtask
endmodule // ser_remote_ctl
`default_nettype wire

// ### ser_status_event.v
// Status and event reporting block: event masks, sticky event flags, status summary byte.
// Assumes a command decoder on the same clock issues one-cycle command strobes.
//
// Contract
// R01 - Clear-status clears every event flag and the summary bits derived from them.
// R02 - Clear-status also empties the pending error records.
// R03 - Event mask stores any 8-bit value written and returns it on query.
// R04 - Event mask reads zero after power-up.
// R05 - Any enabled event flag set raises event summary bit 5 of the status byte.
// R06 - Event mask bits 7..0 map power-on down to operation complete.
// R07 - Flag query returns implemented flags; bits 6 and 1 always read zero.
// R08 - After operation-complete command finishes, flag query returns operation complete set.
// R09 - Service request mask stores 8-bit writes and reads zero after power-up.
// R10 - Service request mask query returns zero in unassigned bits.
// R11 - Status byte query returns the current 8-bit summary value.
// R12 - Status byte bits: aux high 7, event 5, output 4, aux low 3, error 2.
// R13 - Operation-complete flag sets only once the present operation has completed.
`timescale 1ns/1ps
`default_nettype none
`include "ser_defines.vh"

module ser_status_event (
	// Clock, reset and enable.
	input wire clk_i,
	input wire arst_n_i,
	input wire ce_i,
	// Commands.
	input wire clear_status_i,
	input wire event_mask_wr_i,
	input wire srq_mask_wr_i,
	input wire [7:0] wr_data_i,
	input wire op_complete_cmd_i,
	input wire op_busy_i,
	// Queries.
	input wire query_i,
	input wire [1:0] query_sel_i,
	output reg [7:0] resp_data_o,
	output reg resp_valid_o,
	// Event pulses from the rest of the instrument.
	input wire command_syntax_fault_i,
	input wire run_fault_i,
	input wire device_dependent_fault_i,
	input wire query_fault_i,
	// Summary levels from other groups.
	input wire output_available_i,
	input wire aux_event_summary_low_i,
	input wire aux_event_summary_high_i,
	input wire error_pending_i,
	// Outputs.
	output reg error_clear_o,
	output reg [7:0] status_summary_byte_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Internal state and next values.
	reg [7:0] standard_event_mask_q;
	reg [7:0] standard_event_mask_d;
	reg [7:0] service_request_mask_q;
	reg [7:0] service_request_mask_d;
	reg op_pending_q;
	reg op_pending_d;
	reg [7:0] status_d;
	reg error_clear_d;
	reg [7:0] resp_data_d;
	reg resp_valid_d;
	reg [7:0] flag_set;
	reg [7:0] flag_clr;
	wire [7:0] standard_event_flags;
	wire flag_query;
	wire op_done;

	////////////////////////////////////////////////////////////////////////////////
	// Shared decoding.
	function ser_query_hit;
		input query;
		input [1:0] sel;
		input [1:0] code;
		begin
			ser_query_hit = query && (sel == code);
		end
	endfunction

	// Unassigned positions are masked on the service request mask write and on the flag answer.
	function [7:0] ser_keep_used;
		input [7:0] value;
		input [7:0] used;
		begin
			ser_keep_used = value & used;
		end
	endfunction

	// Event summary: any flag that is also enabled.
	function ser_any_enabled;
		input [7:0] flags;
		input [7:0] mask;
		begin
			ser_any_enabled = |(flags & mask);
		end
	endfunction

	function [7:0] ser_clear_vector;
		input clear;
		input read;
		begin
			ser_clear_vector = (clear || read) ? 8'hFF : 8'h00;
		end
	endfunction

	// Only implemented flag positions get a source; the rest of the vector is zero.
	function [7:0] ser_event_set;
		input cmd_fault;
		input exec_fault;
		input dev_fault;
		input qry_fault;
		input op_finished;
		begin
			ser_event_set = 8'h00;
			ser_event_set[`SER_EV_CMD_FAULT] = cmd_fault;
			ser_event_set[`SER_EV_RUN_FAULT] = exec_fault;
			ser_event_set[`SER_EV_DEV_FAULT] = dev_fault;
			ser_event_set[`SER_EV_QUERY_FAULT] = qry_fault;
			ser_event_set[`SER_EV_OP_COMPLETE] = op_finished;
		end
	endfunction

	// Bits 6, 1 and 0 have no source and stay zero.
	function [7:0] ser_summary;
		input aux_high;
		input [7:0] flags;
		input [7:0] mask;
		input avail;
		input aux_low;
		input err;
		begin
			ser_summary = 8'h00;
			ser_summary[`SER_SB_AUX_HIGH] = aux_high;
			ser_summary[`SER_SB_EVENT_SUMMARY] = ser_any_enabled(flags, mask);
			ser_summary[`SER_SB_OUTPUT_AVAILABLE] = avail;
			ser_summary[`SER_SB_AUX_LOW] = aux_low;
			ser_summary[`SER_SB_ERROR_SUMMARY] = err;
		end
	endfunction

	// Flag answers are masked again, so unimplemented positions read zero in any case.
	function [7:0] ser_answer;
		input [1:0] sel;
		input [7:0] ev_mask;
		input [7:0] flags;
		input [7:0] srq_mask;
		input [7:0] status;
		begin
			case (sel)
				`SER_Q_EVENT_MASK: begin
					ser_answer = ev_mask;
				end
				`SER_Q_EVENT_FLAGS: begin
					ser_answer = ser_keep_used(flags, `SER_FLAGS_USED);
				end
				`SER_Q_SRQ_MASK: begin
					ser_answer = srq_mask;
				end
				default: begin
					ser_answer = status;
				end
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Mask registers.
	always @* begin
		standard_event_mask_d = standard_event_mask_q;
		if (event_mask_wr_i) begin
			standard_event_mask_d = wr_data_i; // R03 R06
		end
	end

	// Unassigned bits are dropped on write, so no later query can show them.
	always @* begin
		service_request_mask_d = service_request_mask_q;
		if (srq_mask_wr_i) begin
			service_request_mask_d = ser_keep_used(wr_data_i, `SER_SRQ_USED); // R09 R10
		end
	end

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			standard_event_mask_q <= `SER_EVENT_MASK_RESET; // R04
		end else if (ce_i) begin
			standard_event_mask_q <= standard_event_mask_d;
		end
	end

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			service_request_mask_q <= `SER_SRQ_MASK_RESET; // R09
		end else if (ce_i) begin
			service_request_mask_q <= service_request_mask_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Operation-complete tracking; a new command while pending simply stays pending.
	// The flag waits for the first idle cycle, so a long operation never reports early.
	assign op_done = op_pending_q & ~op_busy_i; // R13

	always @* begin
		op_pending_d = op_pending_q;
		if (op_complete_cmd_i) begin
			op_pending_d = 1'h1;
		end else if (!op_busy_i) begin
			op_pending_d = 1'h0; // R13
		end
	end

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			op_pending_q <= `SER_PULSE_RESET;
		end else if (ce_i) begin
			op_pending_q <= op_pending_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Flag set and clear; a flag query clears the flags it reports.
	// Set wins over clear in the flag register, so an event landing on a read is kept.
	assign flag_query = ser_query_hit(query_i, query_sel_i, `SER_Q_EVENT_FLAGS);

	always @* begin
		flag_set = ser_event_set(command_syntax_fault_i, run_fault_i,
			device_dependent_fault_i, query_fault_i, op_done); // R13 R08
	end

	always @* begin
		flag_clr = ser_clear_vector(clear_status_i, flag_query); // R01
	end

	ser_flags u_flags (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.set_i(flag_set),
		.clr_i(flag_clr),
		.flags_o(standard_event_flags)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Status summary byte, refreshed from its sources on every cycle with ce_i high.
	// The byte is registered, so a status query answers with the previous cycle's value.
	always @* begin
		status_d = ser_summary(aux_event_summary_high_i, standard_event_flags,
			standard_event_mask_q, output_available_i, aux_event_summary_low_i,
			error_pending_i); // R05 R01 R12
	end

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			status_summary_byte_o <= `SER_STATUS_RESET;
		end else if (ce_i) begin
			status_summary_byte_o <= status_d; // R11
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Error-record clear notice, one cycle after the clear-status strobe.
	always @* begin
		error_clear_d = clear_status_i; // R02
	end

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			error_clear_o <= `SER_PULSE_RESET;
		end else if (ce_i) begin
			error_clear_o <= error_clear_d; // R02
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Query answers one cycle after the strobe; the data holds until the next query.
	always @* begin
		resp_valid_d = query_i;
		resp_data_d = resp_data_o;
		if (query_i) begin
			resp_data_d = ser_answer(query_sel_i, standard_event_mask_q, standard_event_flags,
				service_request_mask_q, status_summary_byte_o); // R03 R07 R10 R11
		end
	end

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			resp_data_o <= `SER_RESP_RESET;
		end else if (ce_i) begin
			resp_data_o <= resp_data_d;
		end
	end

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			resp_valid_o <= `SER_PULSE_RESET;
		end else if (ce_i) begin
			resp_valid_o <= resp_valid_d;
		end
	end

endmodule // ser_status_event
`default_nettype wire

// ### testbench.sv
// Self-checking bench of the status and event block.
// Assumes the controller model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_i = 1'h0;
	logic arst_n_i = 1'h0;
	logic busy = 1'h0;
	logic [3:0] ev = 4'h0;
	logic [3:0] lv = 4'h0;
	logic ce = 1'h1;
	wire ec;
	wire [3:0] cmd;
	wire [7:0] wd;
	wire [7:0] rd;
	wire [7:0] sb;
	wire [1:0] qs;
	wire q;
	wire rv;
	int failures = 0;
	int checked = 0;
	initial forever #2.5 clk_i = ~clk_i;
	ser_remote_ctl ser_remote_ctl_inst (.clk_i(clk_i), .cmd_o(cmd), .wr_data_o(wd),
		.query_o(q), .query_sel_o(qs));
	ser_status_event ser_status_event_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce),
		.clear_status_i(cmd[0]), .event_mask_wr_i(cmd[1]), .srq_mask_wr_i(cmd[2]),
		.wr_data_i(wd), .op_complete_cmd_i(cmd[3]), .op_busy_i(busy), .query_i(q),
		.query_sel_i(qs), .resp_data_o(rd), .resp_valid_o(rv), .command_syntax_fault_i(ev[3]),
		.run_fault_i(ev[2]), .device_dependent_fault_i(ev[1]), .query_fault_i(ev[0]),
		.output_available_i(lv[0]), .aux_event_summary_low_i(lv[1]),
		.aux_event_summary_high_i(lv[2]), .error_pending_i(lv[3]), .error_clear_o(ec),
		.status_summary_byte_o(sb));
	////////////////////////////////////////
	task automatic complete_run;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic ask(input logic [1:0] s, input logic [7:0] e, input string n);
		int i;
		ser_remote_ctl_inst.ask(s);
		for (i = 0; i < 4 && rv !== 1'h1; i++) begin
			@(posedge clk_i);
			#1;
		end
		if (rv !== 1'h1) begin
			failures++;
			complete_run();
		end else begin
			chk(n, e, rd);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	////////////////////////////////////////
	initial begin
		idle(20);
		arst_n_i = 1'h1;
		ask(2'h0, 8'h00, "event mask");
		ask(2'h2, 8'h00, "service mask");
		ask(2'h1, 8'h80, "flags");
		ser_remote_ctl_inst.send(1, 8'hFF);
		ask(2'h0, 8'hFF, "event mask");
		ser_remote_ctl_inst.send(2, 8'hFF);
		ask(2'h2, 8'hBC, "service mask");
		$display("test masks done");
		ser_remote_ctl_inst.send(1, 8'hDF);
		idle(1);
		ev[3] = 1'h1;
		idle(1);
		ev = 4'h0;
		idle(3);
		chk("masked summary", 8'h00, sb);
		ser_remote_ctl_inst.send(1, 8'h20);
		idle(3);
		ask(2'h3, 8'h20, "status byte");
		ser_remote_ctl_inst.send(0, 8'h00);
		chk("error clear", 8'h01, {7'h00, ec});
		idle(3);
		chk("cleared summary", 8'h00, sb);
		ask(2'h1, 8'h00, "flags");
		$display("test summary done");
		busy = 1'h1;
		ser_remote_ctl_inst.send(3, 8'h00);
		idle(4);
		ask(2'h1, 8'h00, "flags");
		busy = 1'h0;
		idle(3);
		ask(2'h1, 8'h01, "flags");
		$display("test completion done");
		ev = 4'h7;
		idle(1);
		ev = 4'h0;
		idle(1);
		ask(2'h1, 8'h1C, "flags");
		$display("test faults done");
		lv = 4'hF;
		idle(3);
		ask(2'h3, 8'h9C, "status byte");
		$display("test levels done");
		idle(1);
		ce = 1'h0;
		ser_remote_ctl_inst.send(1, 8'h55);
		ce = 1'h1;
		ask(2'h0, 8'h20, "frozen mask");
		$display("test enable done");
		arst_n_i = 1'h0;
		idle(2);
		arst_n_i = 1'h1;
		ask(2'h0, 8'h00, "event mask");
		ask(2'h2, 8'h00, "service mask");
		ask(2'h1, 8'h80, "flags");
		$display("test reset done");
		complete_run();
	end
endmodule // testbench
`default_nettype wire
